// >>> pxb_alloc.sv
`timescale 1ns/1ps
module pxb_alloc (
    input  wire logic [pxb_pkg::NSIG-1:0]      sig_en,
    input  wire logic [pxb_pkg::NPIN-1:0]      pin_skip,
    output logic      [pxb_pkg::NPIN-1:0]      pin_claim,
    output logic      [pxb_pkg::NPIN-1:0][4:0] pin_sig
);
    import pxb_pkg::*;

    // ------------------------------------------------------------
    // Priority allocation
    // ------------------------------------------------------------
    // Every enable combination walks the same order, so each gives its own pinout until the free pins run out; signals past that get no pin
    always_comb begin
        logic [5:0] next_pin;
        logic       done;
        next_pin  = '0;
        done      = 1'b0;
        pin_claim = '0;
        pin_sig   = '0;
        for (int s = 0; s < NSIG; s++) begin
            if (sig_en[s]) begin
                done = 1'b0;
                for (int q = 0; q < NPIN; q++) begin
                    if (!done && 6'(q) >= next_pin && !pin_skip[q]) begin
                        pin_claim[q] = 1'b1;
                        pin_sig[q]   = 5'(s);
                        next_pin     = 6'(q + 1);
                        done         = 1'b1;
                    end
                end
            end
        end
    end

endmodule

// >>> pxb_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Board side of the pins: weak pull-ups and an outside driver
// ------------------------------------------------------------
module pxb_pin_model (
    input  wire logic [pxb_pkg::NPIN-1:0] pin_o,
    input  wire logic [pxb_pkg::NPIN-1:0] pin_oe_n,
    input  wire logic [pxb_pkg::NPIN-1:0] ext_val,
    input  wire logic [pxb_pkg::NPIN-1:0] ext_en,
    output logic      [pxb_pkg::NPIN-1:0] pin_lvl
);
    import pxb_pkg::*;
    // Released pins float up unless the outside driver is on, never hold a stale driven value
    assign pin_lvl = (~pin_oe_n & pin_o) | (pin_oe_n & ((ext_en & ext_val) | ~ext_en));
endmodule

// >>> pxb_pkg.sv
package pxb_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NPIN   = 32;
    localparam int unsigned NSIG   = 28;
    localparam int unsigned ADDR_W = 12;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_DATA  = 12'h000;
    localparam logic [11:0] OFS_MODE  = 12'h010;
    localparam logic [11:0] OFS_XCFG0 = 12'h020;
    localparam logic [11:0] OFS_XCFG1 = 12'h024;
    localparam logic [11:0] OFS_XCFG2 = 12'h028;
    localparam logic [11:0] OFS_P1IN  = 12'h02C;
    localparam logic [11:0] OFS_LATCH = 12'h030;
    localparam logic [11:0] OFS_BIT   = 12'h040;
    localparam logic [11:0] OFS_BITL  = 12'h0C0;
    localparam logic [11:0] WIN_SPAN  = 12'h080;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DATA = 8'hFF;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_XBR  = 8'h00;
    localparam logic [7:0] RST_P1IN = 8'hFF;

    // ------------------------------------------------------------
    // Crossbar configuration fields
    // ------------------------------------------------------------
    localparam int unsigned X0_SMB   = 0;
    localparam int unsigned X0_SPI   = 1;
    localparam int unsigned X0_UART0 = 2;
    localparam int unsigned X0_PCA   = 3;
    localparam int unsigned X0_ECI   = 6;
    localparam int unsigned X0_CP0   = 7;
    localparam int unsigned X1_CP1   = 0;
    localparam int unsigned X1_T0    = 1;
    localparam int unsigned X1_INT0  = 2;
    localparam int unsigned X1_T1    = 3;
    localparam int unsigned X1_INT1  = 4;
    localparam int unsigned X1_T2    = 5;
    localparam int unsigned X1_T2EX  = 6;
    localparam int unsigned X1_SYSCK = 7;
    localparam int unsigned X2_CNV   = 0;
    localparam int unsigned X2_UART1 = 2;
    localparam int unsigned X2_T4    = 3;
    localparam int unsigned X2_T4EX  = 4;
    localparam int unsigned X2_GLOBAL_EN = 6;

    // ------------------------------------------------------------
    // Peripheral signals in crossbar priority order
    // ------------------------------------------------------------
    localparam logic [4:0]  SIG_UART0_RX = 5'h01;
    localparam logic [4:0]  SIG_UART1_RX = 5'h09;
    localparam logic [31:0] SIG_IN_MASK  = 32'h0BFC8202;
    localparam logic [31:0] SIG_OD_MASK  = 32'h000000C0;

    localparam logic       HRESP_OKAY = 1'b0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic [7:0] x2;
        logic [7:0] x1;
        logic [7:0] x0;
    } pxb_xbar_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              word;
        logic [ADDR_W-1:0] addr;
    } pxb_areq_t;

endpackage

// >>> pxb_port_io.sv
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pxb_port_io (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    input  wire logic [pxb_pkg::NPIN-1:0] pin_i,
    output logic      [pxb_pkg::NPIN-1:0] pin_o,
    output logic      [pxb_pkg::NPIN-1:0] pin_oe_n,
    input  wire logic [pxb_pkg::NSIG-1:0] periph_dout,
    output logic      [pxb_pkg::NSIG-1:0] periph_din,
    input  wire logic                     uart0_mode0,
    input  wire logic                     uart1_mode0
);
    import pxb_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic in_blk(input logic [11:0] a, input logic [11:0] base);
        return (a[11:4] == base[11:4]) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic in_win(input logic [11:0] a, input logic [11:0] base);
        return (a >= base) && (a < base + WIN_SPAN) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [4:0] win_idx(input logic [11:0] a, input logic [11:0] base);
        logic [11:0] rel;
        rel = a - base;
        return rel[6:2];
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pxb_areq_t              req_r,      req_nxt;
    logic      [NPIN-1:0]   data_r,     data_nxt;
    logic      [NPIN-1:0]   mode_r,     mode_nxt;
    pxb_xbar_t              xbar_r,     xbar_nxt;
    logic      [7:0]        p1in_r,     p1in_nxt;
    logic      [31:0]       hrdata_r,   hrdata_nxt;
    logic      [NPIN-1:0]   sync1_r,    sync2_r;
    logic      [NPIN-1:0]   pin_o_r,    pin_o_nxt;
    logic      [NPIN-1:0]   oe_n_r,     oe_n_nxt;
    logic      [NSIG-1:0]   din_r,      din_nxt;
    logic                   hreadyout_r;
    logic                   hresp_r;

    logic      [NSIG-1:0]      sig_en;
    logic      [NPIN-1:0]      skip;
    logic      [NPIN-1:0]      claim;
    logic      [NPIN-1:0][4:0] sig_of;
    logic      [NPIN-1:0]      pval;
    logic      [NPIN-1:0]      in_m;
    logic      [NPIN-1:0]      fod_m;
    logic      [NPIN-1:0]      pp_m;
    logic      [NPIN-1:0]      readback;
    logic                      crossbar_global_enable;
    logic                      rd_req;

    assign crossbar_global_enable = xbar_r.x2[X2_GLOBAL_EN];
    assign skip                   = {16'h0000, ~p1in_r, 8'h00};
    assign readback               = sync2_r & ~skip;
    assign rd_req                 = hsel && htrans[1] && hready && !hwrite;

    // ------------------------------------------------------------
    // Crossbar enables and allocation
    // ------------------------------------------------------------
    always_comb begin
        sig_en        = '0;
        sig_en[1:0]   = {2{xbar_r.x0[X0_UART0]}};
        sig_en[5:2]   = {4{xbar_r.x0[X0_SPI]}};
        sig_en[7:6]   = {2{xbar_r.x0[X0_SMB]}};
        sig_en[9:8]   = {2{xbar_r.x2[X2_UART1]}};
        for (int k = 0; k < 5; k++) begin
            sig_en[10 + k] = xbar_r.x0[X0_PCA +: 3] > 3'(k);
        end
        sig_en[15] = xbar_r.x0[X0_ECI];
        sig_en[16] = xbar_r.x0[X0_CP0];
        sig_en[17] = xbar_r.x1[X1_CP1];
        sig_en[18] = xbar_r.x1[X1_T0];
        sig_en[19] = xbar_r.x1[X1_INT0];
        sig_en[20] = xbar_r.x1[X1_T1];
        sig_en[21] = xbar_r.x1[X1_INT1];
        sig_en[22] = xbar_r.x1[X1_T2];
        sig_en[23] = xbar_r.x1[X1_T2EX];
        sig_en[24] = xbar_r.x2[X2_T4];
        sig_en[25] = xbar_r.x2[X2_T4EX];
        sig_en[26] = xbar_r.x1[X1_SYSCK];
        sig_en[27] = xbar_r.x2[X2_CNV];
    end

    pxb_alloc u_alloc (
        .sig_en    (sig_en),
        .pin_skip  (skip),
        .pin_claim (claim),
        .pin_sig   (sig_of)
    );

    // ------------------------------------------------------------
    // Per-pin drive attributes
    // ------------------------------------------------------------
    always_comb begin
        logic m0;
        m0    = 1'b0;
        pval  = '0;
        in_m  = '0;
        fod_m = '0;
        for (int q = 0; q < NPIN; q++) begin
            m0 = (sig_of[q] == SIG_UART0_RX && uart0_mode0) || (sig_of[q] == SIG_UART1_RX && uart1_mode0);
            pval[q]  = periph_dout[sig_of[q]];
            in_m[q]  = claim[q] && SIG_IN_MASK[sig_of[q]] && !m0;
            fod_m[q] = claim[q] && (SIG_OD_MASK[sig_of[q]] || m0);
        end
        pp_m = mode_r & ~fod_m;
    end

    // ------------------------------------------------------------
    // Register file and AHB-Lite slave
    // ------------------------------------------------------------
    // Zero wait state; a read issued while a write is still in data
    // phase would see the old value, single transfers never overlap
    always_comb begin
        logic [11:0] a;
        a          = req_r.addr;
        req_nxt    = '{valid: hsel && htrans[1] && hready, write: hwrite,
                       word: hsize == HSIZE_WORD, addr: haddr[11:0]};
        data_nxt   = data_r;
        mode_nxt   = mode_r;
        xbar_nxt   = xbar_r;
        p1in_nxt   = p1in_r;
        hrdata_nxt = '0;
        if (req_r.valid && req_r.write && req_r.word) begin
            if (in_blk(a, OFS_DATA)) begin
                data_nxt[{a[3:2], 3'h0} +: 8] = hwdata[7:0];
            end else if (in_blk(a, OFS_MODE)) begin
                mode_nxt[{a[3:2], 3'h0} +: 8] = hwdata[7:0];
            end else if (a == OFS_XCFG0) begin
                xbar_nxt.x0 = hwdata[7:0];
            end else if (a == OFS_XCFG1) begin
                xbar_nxt.x1 = hwdata[7:0];
            end else if (a == OFS_XCFG2) begin
                xbar_nxt.x2 = hwdata[7:0];
            end else if (a == OFS_P1IN) begin
                p1in_nxt = hwdata[7:0];
            end else if (in_win(a, OFS_BIT)) begin
                data_nxt[win_idx(a, OFS_BIT)] = hwdata[0];
            end
        end
        if (rd_req) begin
            if (in_blk(haddr[11:0], OFS_DATA)) begin
                hrdata_nxt[7:0] = readback[{haddr[3:2], 3'h0} +: 8];
            end else if (in_blk(haddr[11:0], OFS_LATCH)) begin
                hrdata_nxt[7:0] = data_r[{haddr[3:2], 3'h0} +: 8];
            end else if (in_blk(haddr[11:0], OFS_MODE)) begin
                hrdata_nxt[7:0] = mode_r[{haddr[3:2], 3'h0} +: 8];
            end else if (haddr[11:0] == OFS_XCFG0) begin
                hrdata_nxt[7:0] = xbar_r.x0;
            end else if (haddr[11:0] == OFS_XCFG1) begin
                hrdata_nxt[7:0] = xbar_r.x1;
            end else if (haddr[11:0] == OFS_XCFG2) begin
                hrdata_nxt[7:0] = xbar_r.x2;
            end else if (haddr[11:0] == OFS_P1IN) begin
                hrdata_nxt[7:0] = p1in_r;
            end else if (in_win(haddr[11:0], OFS_BIT)) begin
                hrdata_nxt[0] = readback[win_idx(haddr[11:0], OFS_BIT)];
            end else if (in_win(haddr[11:0], OFS_BITL)) begin
                hrdata_nxt[0] = data_r[win_idx(haddr[11:0], OFS_BITL)];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r       <= '0;
            data_r      <= {4{RST_DATA}};
            mode_r      <= {4{RST_MODE}};
            xbar_r      <= {3{RST_XBR}};
            p1in_r      <= RST_P1IN;
            hrdata_r    <= '0;
            hreadyout_r <= 1'b1;
            hresp_r     <= HRESP_OKAY;
        end else begin
            req_r       <= req_nxt;
            data_r      <= data_nxt;
            mode_r      <= mode_nxt;
            xbar_r      <= xbar_nxt;
            p1in_r      <= p1in_nxt;
            hrdata_r    <= hrdata_nxt;
            hreadyout_r <= 1'b1;
            hresp_r     <= HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers and peripheral inputs
    // ------------------------------------------------------------
    // Open-drain releases with oe_n high and pin_o parked at 0
    always_comb begin
        logic v;
        v         = 1'b0;
        pin_o_nxt = '0;
        oe_n_nxt  = '1;
        din_nxt   = '1;
        for (int q = 0; q < NPIN; q++) begin
            v = claim[q] ? pval[q] : data_r[q];
            if (crossbar_global_enable && !in_m[q]) begin
                if (pp_m[q]) begin
                    pin_o_nxt[q] = v;
                    oe_n_nxt[q]  = 1'b0;
                end else begin
                    pin_o_nxt[q] = 1'b0;
                    oe_n_nxt[q]  = v;
                end
            end
            if (claim[q]) begin
                din_nxt[sig_of[q]] = sync2_r[q];
            end
        end
    end

    // Pins are asynchronous, two flops before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= '1;
            sync2_r <= '1;
            pin_o_r <= '0;
            oe_n_r  <= '1;
            din_r   <= '1;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            pin_o_r <= pin_o_nxt;
            oe_n_r  <= oe_n_nxt;
            din_r   <= din_nxt;
        end
    end

    assign hrdata     = hrdata_r;
    assign hreadyout  = hreadyout_r;
    assign hresp      = hresp_r;
    assign pin_o      = pin_o_r;
    assign pin_oe_n   = oe_n_r;
    assign periph_din = din_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [NPIN-1:0] gp_m;
    assign gp_m = ~claim & {NPIN{crossbar_global_enable}};

    property p_off_until_enable;
        !crossbar_global_enable |=> (pin_oe_n == '1);
    endproperty
    a_off_until_enable: assert property (p_off_until_enable) else $error("driver on before crossbar enable");

    property p_gpio_push_pull;
        ##1 (((pin_o ^ $past(data_r)) | ~pin_oe_n ^ '1) & $past(gp_m & mode_r)) == '0;
    endproperty
    a_gpio_push_pull: assert property (p_gpio_push_pull) else $error("push-pull gpio pin wrong");

    property p_gpio_open_drain;
        ##1 (((pin_oe_n ^ $past(data_r)) | pin_o) & $past(gp_m & ~mode_r)) == '0;
    endproperty
    a_gpio_open_drain: assert property (p_gpio_open_drain) else $error("open-drain gpio pin wrong");

    property p_claimed_follows;
        ##1 ((pin_o ^ $past(pval)) & $past(claim & pp_m & ~in_m) & {NPIN{$past(crossbar_global_enable)}}) == '0;
    endproperty
    a_claimed_follows: assert property (p_claimed_follows) else $error("claimed pin ignores peripheral");

    property p_input_released;
        ##1 (~pin_oe_n & $past(in_m)) == '0;
    endproperty
    a_input_released: assert property (p_input_released) else $error("input pin driven");

    property p_forced_od;
        ##1 (pin_o & ~pin_oe_n & $past(fod_m)) == '0;
    endproperty
    a_forced_od: assert property (p_forced_od) else $error("forced open-drain pin driven high");

    property p_latch_read;
        (rd_req && in_blk(haddr[11:0], OFS_LATCH)) |=> (hrdata[7:0] == $past(data_r[{haddr[3:2], 3'h0} +: 8]));
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latched read wrong");

    property p_analog_reads_zero;
        (rd_req && haddr[11:0] == OFS_DATA + 12'h004) |=> ((hrdata[7:0] & ~$past(p1in_r)) == 8'h00);
    endproperty
    a_analog_reads_zero: assert property (p_analog_reads_zero) else $error("analog pin read not zero");

    property p_pin_read;
        (rd_req && haddr[11:0] == OFS_DATA) |=> (hrdata[7:0] == $past(sync2_r[7:0]));
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

    property p_bit_write;
        (req_r.valid && req_r.write && req_r.word && in_win(req_r.addr, OFS_BIT))
            |=> ((data_r ^ $past(data_r)) & ~(32'h1 << $past(win_idx(req_r.addr, OFS_BIT)))) == '0;
    endproperty
    a_bit_write: assert property (p_bit_write) else $error("bit write touched other bits");

    property p_uart0_first;
        (sig_en[1:0] == 2'b11) |-> (claim[1:0] == 2'b11 && sig_of[1] == SIG_UART0_RX);
    endproperty
    a_uart0_first: assert property (p_uart0_first) else $error("uart0 not on pins 0 and 1");

    c_enable: cover property (!crossbar_global_enable ##1 crossbar_global_enable);
    c_pp_drive: cover property (crossbar_global_enable && (mode_r & gp_m) != '0);
    c_claimed: cover property (crossbar_global_enable && claim != '0);
    c_latch: cover property (rd_req && in_blk(haddr[11:0], OFS_LATCH));

endmodule

// >>> pxb_port_io_bench.sv
`timescale 1ns/1ps
module pxb_port_io_bench;
    import pxb_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, xe, u0m, u1m;
    logic [31:0] haddr, hwdata, hrdata, pin_o, pin_oe_n, pin_lvl, ext_val, ext_en;
    logic [31:0] data_s, mode_s, rd, v, lvl;
    logic [27:0] pd, pdin;
    logic [15:0] lf;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          fail_count, checked, p, b;

    always #50 hclk = ~hclk;
    assign hready = hreadyout;

    pxb_port_io dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .periph_dout(pd), .periph_din(pdin), .uart0_mode0(u0m), .uart1_mode0(u1m));
    pxb_pin_model pins (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .ext_en(ext_en),
        .pin_lvl(pin_lvl));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [31:0] exp_oe();
        return xe ? (~mode_s & data_s) : 32'hFFFFFFFF;
    endfunction
    task rnd(output logic [31:0] r);
        lf = lfsr(lf);
        r[15:0] = lf;
        lf = lfsr(lf);
        r[31:16] = lf;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task complete_run;
        $display("mismatches %0d comparisons %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task rdy_wait;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            fail_count++;
            complete_run;
        end
    endtask
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h0, a};
        hsize  <= HSIZE_WORD;
        rdy_wait;
        htrans <= 2'h0;
        hwdata <= d;
        rdy_wait;
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task dwr(input int q, input logic [7:0] d);
        data_s[q*8+:8] = d;
        ahb(1'b1, OFS_DATA + 12'(4*q), {24'h0, d});
    endtask
    task mwr(input int q, input logic [7:0] d);
        mode_s[q*8+:8] = d;
        ahb(1'b1, OFS_MODE + 12'(4*q), {24'h0, d});
    endtask
    task settle;
        repeat (4) @(posedge hclk);
        #1;
    endtask
    task gchk(input string nm, input logic [31:0] m);
        logic [31:0] e;
        settle;
        e = exp_oe();
        chk(nm, e & ~m, pin_oe_n & ~m);
        if (xe) chk(nm, (data_s | e) & ~m, (pin_o | pin_oe_n) & ~m);
    endtask
    // Crossbar is switched off while its layout changes
    task xcfg(input logic [7:0] x0, input logic [7:0] x2);
        ahb(1'b1, OFS_XCFG2, 32'h0);
        ahb(1'b1, OFS_XCFG0, {24'h0, x0});
        ahb(1'b1, OFS_XCFG2, {24'h0, x2});
        settle;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        #5_000_000;
        fail_count++;
        complete_run;
    end
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b1;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        ext_val = 32'h0;
        ext_en = 32'h0;
        pd = 28'h0;
        u0m = 1'b0;
        u1m = 1'b0;
        lf = 16'h0029;
        fail_count = 0;
        checked = 0;
        data_s = 32'hFFFFFFFF;
        mode_s = 32'h0;
        xe = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        for (int q = 0; q < 4; q++) begin
            rdc("pins", OFS_DATA + 12'(4*q), 32'hFF);
            rdc("mode", OFS_MODE + 12'(4*q), 32'h0);
            rdc("latch", OFS_LATCH + 12'(4*q), 32'hFF);
        end
        rdc("xbar", OFS_XCFG2, 32'h0);
        rdc("p1 input mode", OFS_P1IN, 32'hFF);
        ahb(1'b1, 12'h3FC, 32'hFF);
        rdc("unmapped", 12'h3FC, 32'h0);
        dwr(0, 8'h00);
        mwr(1, 8'hFF);
        gchk("drivers off", 0);
        rdc("pins", OFS_DATA, 32'hFF);
        rdc("latch", OFS_LATCH, 32'h0);
        ahb(1'b1, OFS_XCFG2, 32'h40);
        xe = 1'b1;
        gchk("enabled", 0);
        for (int i = 0; i < 16; i++) begin
            rnd(v);
            dwr(v[1:0], v[15:8]);
            mwr(v[3:2], v[23:16]);
            b = v[28:24];
            data_s[b] = v[29];
            ahb(1'b1, OFS_BIT + 12'(4*b), {31'h0, v[29]});
            rdc("latch bit", OFS_BITL + 12'(4*b), {31'h0, v[29]});
            gchk("gpio drive", 0);
            rnd(v);
            @(posedge hclk);
            ext_val <= v;
            ext_en <= exp_oe();
            settle;
            lvl = (exp_oe() & v) | (~exp_oe() & data_s);
            p = i % 4;
            rdc("pin byte", OFS_DATA + 12'(4*p), {24'h0, lvl[p*8+:8]});
            rdc("pin bit", OFS_BIT + 12'(4*b), {31'h0, lvl[b]});
        end
        for (int q = 0; q < 4; q++) begin
            mwr(q, 8'hFF);
            dwr(q, 8'hFF);
        end
        rnd(v);
        pd <= v[27:0];
        u0m <= 1'b1;
        ext_en <= 32'h0;
        xcfg(8'h05, 8'h40);
        chk("uart smb oe", {28'h0, pd[7], pd[6], pd[1], 1'b0}, {28'h0, pin_oe_n[3:0]});
        chk("tx0 out", {31'h0, pd[0]}, {31'h0, pin_o[0]});
        dwr(0, 8'h00);
        gchk("gpio beside claims", 32'hF);
        chk("claims ignore data", {28'h0, pd[7], pd[6], pd[1], 1'b0}, {28'h0, pin_oe_n[3:0]});
        @(posedge hclk);
        u0m <= 1'b0;
        ext_en <= 32'h2;
        ext_val <= ~v;
        settle;
        chk("uart0 receive driver", 32'h1, {31'h0, pin_oe_n[1]});
        chk("uart0 receive level", {31'h0, ~v[1]}, {31'h0, pdin[1]});
        xcfg(8'h07, 8'h40);
        chk("spi smb oe", {24'h0, pd[7], pd[6], 6'h02}, {24'h0, pin_oe_n[7:0]});
        chk("sck out", {31'h0, pd[2]}, {31'h0, pin_o[2]});
        ahb(1'b1, OFS_P1IN, 32'hFE);
        xcfg(8'h0F, 8'h40);
        chk("skip oe", 32'h0, {30'h0, pin_oe_n[9:8]});
        chk("skip out", {30'h0, pd[10], 1'b1}, {30'h0, pin_o[9:8]});
        rdc("analog read", OFS_DATA + 12'h004, {24'h0, 6'h3F, pd[10], 1'b0});
        // Second uart in mode 0: its receive pin turns open-drain
        u1m <= 1'b1;
        xcfg(8'h0F, 8'h44);
        chk("uart1 receive oe", {30'h0, pd[9], 1'b0}, {30'h0, pin_oe_n[10:9]});
        chk("tx1 out", {31'h0, pd[8]}, {31'h0, pin_o[9]});
        complete_run;
    end
endmodule
